// *** rtl/pcsr_pkg.sv ***
// pcsr_pkg: constants and carrier types for the power, clock and status register bank
// assumes a byte-wide host port with a six-bit register address
`default_nettype none

package pcsr_pkg;
  localparam int unsigned AW = 6;
  // register addresses
  localparam logic [5:0] ADDR_MODEM_STAT = 6'h01;  // read: modem_event_status
  localparam logic [5:0] ADDR_MODE       = 6'h03;  // write: mode
  localparam logic [5:0] ADDR_SYNTH_STAT = 6'h03;  // read: synth_and_aux_status
  localparam logic [5:0] ADDR_PWR_PRI    = 6'h04;
  localparam logic [5:0] ADDR_PWR_SEC    = 6'h05;
  localparam logic [5:0] ADDR_CLK_CFG    = 6'h3F;  // placement not fixed by the map
  // field positions
  localparam int unsigned MODE_IRQ_EN_BIT  = 7;
  localparam int unsigned MODE_LOCK_IRQ_BIT = 3;
  localparam int unsigned SEC_RESET_BIT     = 3;
  localparam int unsigned SEC_EXTAMP_BIT    = 2;
  localparam int unsigned PRI_VREG_BIT      = 5;
  // retained across soft reset
  localparam logic [7:0] PRI_KEEP_MASK = 8'h20;
  localparam logic [7:0] SEC_KEEP_MASK = 8'h03;
  // reset values
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [3:0] NIB_SIXTEEN = 4'h0;
  localparam logic [4:0] SIXTEEN    = 5'h10;
  // synchroniser depth for pins
  localparam int unsigned SYNC_STAGES = 3;

  typedef struct packed {
    logic       clk_buf_en;
    logic       baseband_en;
    logic       vreg_en;
    logic       opamp_pair_enable;
    logic       rx_if_en;
    logic       receive_front_enable;
    logic       receive_mixer_out_enable;
    logic       transmit_path_enable;
  } pcsr_pri_type;

  typedef struct packed {
    logic [3:0] aux_converter_enables;
    logic       soft_reset;
    logic       external_amp_control;
    logic       preserve;
    logic       bias_en;
  } pcsr_sec_type;

  // modem-side event inputs: pulses from modem logic on this clock
  typedef struct packed {
    logic buffer_free_flag;
    logic input_buffer_empty_flag;
    logic data_buffer_overflow_flag;
    logic check_result_flag;
    logic quality_ready_flag;
    logic frame_type_flag;
    logic packet_detect;
  } pcsr_modem_ev_type;

  // decodes a clock nibble: 0000 means sixteen
  function automatic logic [4:0] pcsr_nib_factor(input logic [3:0] n);
    pcsr_nib_factor = (n == NIB_SIXTEEN) ? SIXTEEN : {1'b0, n};
  endfunction
endpackage

`default_nettype wire

// *** rtl/pcsr_sync.sv ***
// pcsr_sync: three-stage synchroniser with agreement on the last two stages
// assumes the input is asynchronous to mclk_i
`default_nettype none

module pcsr_sync #(
  parameter int unsigned W = 3
) (
  input  wire logic         mclk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] level_o
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] lvl_q;
  wire  [W-1:0] agree_w = ~(s2_q ^ s3_q);

  // first stage feeds only the second
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      lvl_q <= '0;
    end else begin
      s1_q  <= async_i;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      lvl_q <= (agree_w & s3_q) | (~agree_w & lvl_q);
    end
  end
  assign level_o = lvl_q;
endmodule

`default_nettype wire

// *** rtl/pcsr_top.sv ***
// pcsr_top: power enables, soft reset, clock config and status registers
// assumes a byte-wide host port on mclk_i: cs/rd/wr strobes are pin-level and synchronised
`default_nettype none

module pcsr_top (
  input  wire logic                      mclk_i,
  input  wire logic                      rst_i,
  // host byte port (pins)
  input  wire logic                      cs_n_i,
  input  wire logic                      rd_n_i,
  input  wire logic                      wr_n_i,
  input  wire logic [pcsr_pkg::AW-1:0]   addr_i,
  input  wire logic [7:0]                data_i,
  output logic      [7:0]                data_o,
  output logic                           data_oe_o,
  output logic                           host_interrupt_n_o,
  // block events from on-chip logic, same clock, one-cycle pulses; adc_continuous_i and rx_mode_i are mode levels
  input  wire pcsr_pkg::pcsr_modem_ev_type modem_ev_i,
  input  wire logic                      spc_done_i,
  input  wire logic                      adc_done_i,
  input  wire logic                      adc_continuous_i,
  input  wire logic                      rx_mode_i,
  input  wire logic                      freq_err_i,
  input  wire logic                      iq_done_i,
  // lock levels from the synthesisers, asynchronous
  input  wire logic [2:0]                pll_lock_i,
  // power enables and pins
  output pcsr_pkg::pcsr_pri_type         pwr_pri_o,
  output pcsr_pkg::pcsr_sec_type         pwr_sec_o,
  output logic                           external_amp_control_o,
  output logic                           amp_out_oe_o,
  output logic                           rx_unreliable_o,
  output logic                           preserve_special_o,
  output logic [4:0]                     base_mult_o,
  output logic [4:0]                     ref_div_o
);
  import pcsr_pkg::*;

  // host strobes pass the pin synchroniser; address and data are held stable by the host
  logic [2:0] strb_w;
  logic [2:0] lock_w;
  pcsr_sync #(.W(3)) u_sync_strb (
    .mclk_i  (mclk_i),
    .rst_i   (rst_i),
    .async_i ({~cs_n_i, ~rd_n_i, ~wr_n_i}),
    .level_o (strb_w)
  );
  // lock inputs are held through the same three-stage scheme
  pcsr_sync #(.W(3)) u_sync_lock (
    .mclk_i  (mclk_i),
    .rst_i   (rst_i),
    .async_i (pll_lock_i),
    .level_o (lock_w)
  );

  logic [2:0] strb_q;
  wire rd_lvl_w  = strb_w[2] & strb_w[1];
  wire wr_lvl_w  = strb_w[2] & strb_w[0];
  wire rd_pulse_w = rd_lvl_w & ~(strb_q[2] & strb_q[1]);
  wire wr_pulse_w = wr_lvl_w & ~(strb_q[2] & strb_q[0]);

  // registers
  logic [7:0] pri_q, pri_d;
  logic [7:0] sec_q, sec_d;
  logic [7:0] mode_q, mode_d;
  logic [7:0] clk_q, clk_d;
  logic [6:0] st1_q, st1_d;     // low seven bits of modem_event_status
  logic       irq_q, irq_d;     // summary flag
  logic       irq_from1_q, irq_from1_d;
  logic       irq_from2_q, irq_from2_d;
  logic [3:0] st2_q, st2_d;     // bits 3..0 of synth_and_aux_status
  logic       lost_q, lost_d;
  logic [2:0] seen_q, seen_d;   // lock bits read as one
  logic [2:0] lock_prev_q;
  logic [2:0] lock_snap_q;      // held copy for the read in progress
  logic [7:0] rdata_q;
  logic       oe_q;
  logic       host_irq_n_q;  // active-low pin state
  logic       iq_busy_q;

  wire soft_rst_w = sec_q[SEC_RESET_BIT];

  // write and read decode
  wire wr_pri_w  = wr_pulse_w & (addr_i == ADDR_PWR_PRI);
  wire wr_sec_w  = wr_pulse_w & (addr_i == ADDR_PWR_SEC);
  wire wr_mode_w = wr_pulse_w & (addr_i == ADDR_MODE);
  wire wr_clk_w  = wr_pulse_w & (addr_i == ADDR_CLK_CFG);
  wire rd_st1_w  = rd_pulse_w & (addr_i == ADDR_MODEM_STAT);
  wire rd_st2_w  = rd_pulse_w & (addr_i == ADDR_SYNTH_STAT);
  // reading is complete at the trailing edge of the strobe
  wire rd_end_w  = ~rd_lvl_w & (strb_q[2] & strb_q[1]);
  logic [AW-1:0] rd_addr_q;
  wire rd_end1_w = rd_end_w & (rd_addr_q == ADDR_MODEM_STAT);
  wire rd_end2_w = rd_end_w & (rd_addr_q == ADDR_SYNTH_STAT);

  // lock change detection on the synchronised levels
  wire [2:0] lock_fall_w = lock_prev_q & ~lock_w;
  wire       lost_ev_w   = |(lock_fall_w & seen_q);

  // new events, gated so continuous conversion never flags
  wire       adc_ev_w  = adc_done_i & ~adc_continuous_i;
  wire       ferr_ev_w = freq_err_i & rx_mode_i;
  wire [3:0] st2_ev_w  = {spc_done_i, adc_ev_w, ferr_ev_w, iq_done_i};
  wire [6:0] st1_ev_w  = modem_ev_i;

  // rising edges of interrupt-capable bits; lock loss counts only with its mode bit
  wire st1_rise_w = |(st1_ev_w & ~st1_q);
  wire st2_rise_w = |(st2_ev_w & ~st2_q) |
                    (lost_ev_w & ~lost_q & mode_q[MODE_LOCK_IRQ_BIT]);

  // lost-lock never raises itself without a fall of a bit already read high
  AST_LOST_QUIET: assert property (@(posedge mclk_i) disable iff (rst_i)
    (!lost_q && !lost_ev_w) |=> !lost_q)
    else $error("lock lost flag set with no qualifying fall");
  // outside receive mode the offset comparison is idle, so its flag cannot rise
  AST_FERR_RX: assert property (@(posedge mclk_i) disable iff (rst_i)
    (!rx_mode_i && !st2_q[1]) |=> !st2_q[1])
    else $error("offset error flag set outside receive mode");

  // next state: writes, soft reset retention, sticky flags with set over clear
  always_comb begin
    pri_d  = pri_q;
    sec_d  = sec_q;
    mode_d = mode_q;
    clk_d  = clk_q;
    if (wr_pri_w) pri_d = data_i;
    if (wr_sec_w) sec_d = data_i;
    if (wr_mode_w) mode_d = data_i;
    if (wr_clk_w) clk_d = data_i;
    if (soft_rst_w) begin
      // while reset is held everything but the kept bits, the reset bit and the clock setting stays zero
      pri_d  = pri_q & PRI_KEEP_MASK;
      mode_d = REG_RESET;
      sec_d  = (wr_sec_w ? data_i : sec_q) & (SEC_KEEP_MASK | 8'h08);
    end
    st1_d       = (rd_end1_w ? 7'h00 : st1_q) | st1_ev_w;
    st2_d       = (rd_end2_w ? 4'h0 : st2_q) | st2_ev_w;
    lost_d      = (rd_end2_w ? 1'b0 : lost_q) | lost_ev_w;
    seen_d      = (rd_end2_w ? lock_snap_q : seen_q) & ~lock_fall_w;
    irq_from1_d = (rd_end1_w ? 1'b0 : irq_from1_q) | st1_rise_w;
    irq_from2_d = (rd_end2_w ? 1'b0 : irq_from2_q) | st2_rise_w;
    irq_d       = irq_from1_d | irq_from2_d;
    if (soft_rst_w) begin
      st1_d       = 7'h00;
      st2_d       = 4'h0;
      lost_d      = 1'b0;
      seen_d      = 3'h0;
      irq_from1_d = 1'b0;
      irq_from2_d = 1'b0;
      irq_d       = 1'b0;
    end
  end

  // read mux: lock bits are the live levels at read start, the held snapshot otherwise
  wire [7:0] st1_rd_w = {irq_q, st1_q};
  wire [7:0] st2_rd_w = {lost_q, rd_st2_w ? lock_w : lock_snap_q, st2_q};
  wire [7:0] rmux_w   = (addr_i == ADDR_MODEM_STAT) ? st1_rd_w :
                        (addr_i == ADDR_SYNTH_STAT) ? st2_rd_w : 8'h00;

  // read data carries the lock levels seen at the start of the read
  AST_LOCK_RD: assert property (@(posedge mclk_i) disable iff (rst_i)
    rd_st2_w |=> (data_o[6:4] == $past(lock_w)))
    else $error("lock bits in read data not the live levels");
  // a finished status one read leaves no stale flag unless a new event arrived
  AST_ST1_CLR: assert property (@(posedge mclk_i) disable iff (rst_i)
    (rd_end1_w && !(|st1_ev_w)) |=> (st1_q == 7'h00))
    else $error("status one not cleared after read");

  // host-port state and registers
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      pri_q       <= REG_RESET;
      sec_q       <= REG_RESET;
      mode_q      <= REG_RESET;
      clk_q       <= REG_RESET;
      st1_q       <= 7'h00;
      st2_q       <= 4'h0;
      lost_q      <= 1'b0;
      seen_q      <= 3'h0;
      irq_q       <= 1'b0;
      irq_from1_q <= 1'b0;
      irq_from2_q <= 1'b0;
      strb_q      <= 3'h0;
      lock_prev_q <= 3'h0;
      lock_snap_q <= 3'h0;
      rd_addr_q   <= '0;
      rdata_q     <= 8'h00;
      oe_q        <= 1'b0;
    end else begin
      pri_q       <= pri_d;
      sec_q       <= sec_d;
      mode_q      <= mode_d;
      clk_q       <= clk_d;
      st1_q       <= st1_d;
      st2_q       <= st2_d;
      lost_q      <= lost_d;
      seen_q      <= seen_d;
      irq_q       <= irq_d;
      irq_from1_q <= irq_from1_d;
      irq_from2_q <= irq_from2_d;
      strb_q      <= strb_w;
      lock_prev_q <= lock_w;
      if (rd_st2_w) lock_snap_q <= lock_w;
      if (rd_pulse_w) begin
        rd_addr_q <= addr_i;
        rdata_q   <= rmux_w;
      end
      oe_q        <= rd_lvl_w;
    end
  end

  // interrupt pin and receive-unreliable flag, both registered
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      host_irq_n_q <= 1'b1;
      iq_busy_q    <= 1'b0;
    end else begin
      host_irq_n_q <= ~(irq_d & mode_d[MODE_IRQ_EN_BIT]);
      // estimation runs from acquire until done; acquire is seen as a packet detect in receive mode
      if (iq_done_i | soft_rst_w) iq_busy_q <= 1'b0;
      else if (st1_ev_w[0] & rx_mode_i) iq_busy_q <= 1'b1;
    end
  end

  assign data_o             = rdata_q;
  assign data_oe_o          = oe_q;
  assign host_interrupt_n_o = host_irq_n_q;
  assign rx_unreliable_o    = iq_busy_q;

  // with interrupts masked the pin must stay released whatever the flags do
  AST_IRQ_OFF: assert property (@(posedge mclk_i) disable iff (rst_i)
    !mode_d[MODE_IRQ_EN_BIT] |=> host_interrupt_n_o)
    else $error("interrupt pin low while interrupts disabled");
  // reading status one drops the summary when nothing else is pending
  AST_IRQ_CLR1: assert property (@(posedge mclk_i) disable iff (rst_i)
    (rd_end1_w && !st1_rise_w && !irq_from2_q && !st2_rise_w) |=> !irq_q)
    else $error("summary flag not cleared by status one read");
  // estimation done ends the unreliable window at once
  AST_UNREL_CLR: assert property (@(posedge mclk_i) disable iff (rst_i)
    iq_done_i |=> !rx_unreliable_o)
    else $error("receive still unreliable after estimation done");
  // power-on reset leaves pin released, bus undriven and every block off
  AST_RST_IDLE: assert property (@(posedge mclk_i)
    rst_i |=> host_interrupt_n_o && !data_oe_o &&
              (pri_out_q == REG_RESET) && (sec_out_q == REG_RESET))
    else $error("reset did not leave the bank idle");

  logic [7:0] pri_out_q;
  logic [7:0] sec_out_q;
  logic [4:0] mult_q;
  logic [4:0] div_q;
  // zero bits hold their block off; each enable follows its own bit, the regulator bit gates no other
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      pri_out_q <= REG_RESET;
      sec_out_q <= REG_RESET;
      mult_q    <= SIXTEEN;
      div_q     <= SIXTEEN;
    end else begin
      pri_out_q <= pri_d;
      sec_out_q <= sec_d;
      mult_q    <= pcsr_nib_factor(clk_d[7:4]);
      div_q     <= pcsr_nib_factor(clk_d[3:0]);
    end
  end

  assign pwr_pri_o              = pri_out_q;
  assign pwr_sec_o              = sec_out_q;
  assign external_amp_control_o = sec_out_q[SEC_EXTAMP_BIT];
  assign amp_out_oe_o           = pri_out_q[4];
  assign preserve_special_o     = sec_out_q[1];
  assign base_mult_o            = mult_q;
  assign ref_div_o              = div_q;

  // a primary write outside reset reaches the enables one edge later
  AST_PRI_WRITE: assert property (@(posedge mclk_i) disable iff (rst_i)
    (wr_pri_w && !soft_rst_w) |=> (pri_out_q == $past(data_i)))
    else $error("primary enables differ from written value");
  // enables only move on a write or a soft reset
  AST_PRI_HOLD: assert property (@(posedge mclk_i) disable iff (rst_i)
    (!wr_pri_w && !soft_rst_w) |=> (pri_out_q == $past(pri_out_q)))
    else $error("primary enables changed without a write");
  // a secondary write outside reset reaches the enables one edge later
  AST_SEC_WRITE: assert property (@(posedge mclk_i) disable iff (rst_i)
    (wr_sec_w && !soft_rst_w) |=> (sec_out_q == $past(data_i)))
    else $error("secondary enables differ from written value");
  // secondary enables only move on a write or a soft reset
  AST_SEC_HOLD: assert property (@(posedge mclk_i) disable iff (rst_i)
    (!wr_sec_w && !soft_rst_w) |=> (sec_out_q == $past(sec_out_q)))
    else $error("secondary enables changed without a write");
  // soft reset idles every primary block but the regulator
  AST_SOFT_PRI: assert property (@(posedge mclk_i) disable iff (rst_i)
    soft_rst_w |=> ((pri_out_q & ~PRI_KEEP_MASK) == REG_RESET))
    else $error("primary block left on during soft reset");
  // soft reset idles converters and the external amp
  AST_SOFT_SEC: assert property (@(posedge mclk_i) disable iff (rst_i)
    soft_rst_w |=> ((sec_out_q & 8'hF4) == REG_RESET))
    else $error("secondary block left on during soft reset");
  // soft reset also wipes the status flags and the summary
  AST_SOFT_FLAGS: assert property (@(posedge mclk_i) disable iff (rst_i)
    soft_rst_w |=> (st1_q == 7'h00) && (st2_q == 4'h0) && !irq_q && !lost_q)
    else $error("status flag survived soft reset");
  // the clock setting survives soft reset so the baseband clock keeps its rate
  AST_CLK_KEEP: assert property (@(posedge mclk_i) disable iff (rst_i)
    (soft_rst_w && !wr_clk_w) |=> (clk_q == $past(clk_q)))
    else $error("clock setting lost in soft reset");
  // preserve bit itself is one of the retained bits
  AST_PRES_KEEP: assert property (@(posedge mclk_i) disable iff (rst_i)
    (soft_rst_w && !wr_sec_w) |=> (preserve_special_o == $past(sec_q[1])))
    else $error("preserve bit lost in soft reset");
  // a zero multiplier nibble means sixteen
  AST_MULT16: assert property (@(posedge mclk_i) disable iff (rst_i)
    (wr_clk_w && (data_i[7:4] == NIB_SIXTEEN)) |=> (base_mult_o == SIXTEEN))
    else $error("zero multiplier nibble not decoded as sixteen");
  // any other multiplier nibble is taken as its plain value
  AST_MULT_VAL: assert property (@(posedge mclk_i) disable iff (rst_i)
    (wr_clk_w && (data_i[7:4] != NIB_SIXTEEN)) |=> (base_mult_o == {1'b0, $past(data_i[7:4])}))
    else $error("multiplier nibble decoded wrongly");

  // checks
  AST_IRQ_PIN: assert property (@(posedge mclk_i) disable iff (rst_i)
    (irq_q && mode_q[MODE_IRQ_EN_BIT]) |-> !host_interrupt_n_o)
    else $error("interrupt pin not low with enabled flag");
  AST_SOFT_KEEP: assert property (@(posedge mclk_i) disable iff (rst_i)
    soft_rst_w |=> (pri_q[PRI_VREG_BIT] == $past(pri_q[PRI_VREG_BIT])) && (mode_q == 8'h00))
    else $error("soft reset lost a kept bit or kept mode");
  AST_EXTAMP_CLR: assert property (@(posedge mclk_i) disable iff (rst_i)
    (soft_rst_w && !wr_sec_w) |=> ##1 !external_amp_control_o)
    else $error("external amp not cleared by soft reset");
  AST_AMP_OFF: assert property (@(posedge mclk_i) disable iff (rst_i)
    !pri_d[4] |=> !amp_out_oe_o)
    else $error("amp driving while disabled");
  AST_LOST_SET: assert property (@(posedge mclk_i) disable iff (rst_i)
    (lost_ev_w && !soft_rst_w) |=> lost_q)
    else $error("lock lost flag not set");
  AST_ST2_CLR: assert property (@(posedge mclk_i) disable iff (rst_i)
    (rd_end2_w && !(|st2_ev_w)) |=> (st2_q == 4'h0))
    else $error("status two not cleared after read");
  AST_ADC_CONT: assert property (@(posedge mclk_i) disable iff (rst_i)
    (adc_continuous_i && !st2_q[2] && !soft_rst_w) |=> !st2_q[2])
    else $error("conversion flag set in continuous mode");
  AST_SUMMARY: assert property (@(posedge mclk_i) disable iff (rst_i)
    (st1_rise_w && !soft_rst_w) |=> irq_q)
    else $error("summary flag missed a rising event");
  AST_CLK16: assert property (@(posedge mclk_i) disable iff (rst_i)
    (clk_q[3:0] == 4'h0) |=> (ref_div_o == 5'h10) || $changed(clk_q))
    else $error("zero nibble not decoded as sixteen");
endmodule

`default_nettype wire

// *** sim/pcsr_host.sv ***
// pcsr_host: host microcontroller model on the byte-wide register port
// assumes the device synchronises its strobes to mclk_i within four edges
`default_nettype none

module pcsr_host (
  input  wire logic       mclk_i,
  input  wire logic [7:0] bus_i,
  input  wire logic       bus_oe_i,
  output logic            cs_n_o,
  output logic            rd_n_o,
  output logic            wr_n_o,
  output logic [5:0]      addr_o,
  output logic [7:0]      bus_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle port: no strobe, bus shows a value nobody drove
  initial begin
    cs_n_o = 1'b1;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    addr_o = 6'h00;
    bus_o  = 8'hA5;
  end

  // strobe held six edges so synchroniser and register update land first
  task automatic write_reg(input logic [5:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    cs_n_o <= 1'b0;
    wr_n_o <= 1'b0;
    addr_o <= a;
    bus_o  <= d;
    repeat (6) @(posedge mclk_i);
    cs_n_o <= 1'b1;
    wr_n_o <= 1'b1;
    bus_o  <= ~d;  // released bus must not look like held data
    repeat (5) @(posedge mclk_i);
  endtask

  // read waits for the device to drive, bounded so a dead port cannot hang
  task automatic read_reg(input logic [5:0] a, output logic [7:0] d);
    int k;
    @(posedge mclk_i);
    cs_n_o <= 1'b0;
    rd_n_o <= 1'b0;
    addr_o <= a;
    for (k = 0; k < 12 && bus_oe_i !== 1'b1; k++) begin
      @(posedge mclk_i);
    end
    @(posedge mclk_i);
    d = bus_i;
    cs_n_o <= 1'b1;
    rd_n_o <= 1'b1;
    repeat (6) @(posedge mclk_i);  // trailing-edge status clear settles
  endtask
endmodule

`default_nettype wire

// *** sim/tb_power_clock_status_regs.sv ***
// tb_power_clock_status_regs: scenario bench for the power, clock and status bank
// assumes pcsr_pkg, pcsr_top and the pcsr_host model are compiled before it
`default_nettype none
`define CHK(nm, exp, got) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
      $display("[ERR] %s expected %h seen %h", nm, exp, got); \
      n_mismatch++; \
    end \
  end

module tb_power_clock_status_regs;
  timeunit 1ns;
  timeprecision 1ps;
  import pcsr_pkg::*;

  logic              mclk = 1'b0;
  logic              rst  = 1'b1;
  logic              cs_n, rd_n, wr_n, oe, irq_n, ext, amp_oe, unrel, pres;
  logic [5:0]        addr;
  logic [7:0]        wdat, rdat, rv;
  pcsr_modem_ev_type ev   = '0;
  logic [3:0]        s2ev = 4'h0;  // spc, adc, freq, iq
  logic              cont = 1'b0;
  logic              rxm  = 1'b0;
  logic [2:0]        lock = 3'h0;
  pcsr_pri_type      pri;
  pcsr_sec_type      sec;
  logic [4:0]        mult, div;
  int                n_mismatch  = 0;
  int                comparisons = 0;
  int                cyc         = 0;

  // 125 MHz reference clock
  initial begin
    forever #4 mclk = ~mclk;
  end

  pcsr_host host_u (.mclk_i(mclk), .bus_i(rdat), .bus_oe_i(oe), .cs_n_o(cs_n), .rd_n_o(rd_n),
    .wr_n_o(wr_n), .addr_o(addr), .bus_o(wdat));

  pcsr_top dut_u (.mclk_i(mclk), .rst_i(rst), .cs_n_i(cs_n), .rd_n_i(rd_n), .wr_n_i(wr_n),
    .addr_i(addr), .data_i(wdat), .data_o(rdat), .data_oe_o(oe), .host_interrupt_n_o(irq_n),
    .modem_ev_i(ev), .spc_done_i(s2ev[3]), .adc_done_i(s2ev[2]), .adc_continuous_i(cont),
    .rx_mode_i(rxm), .freq_err_i(s2ev[1]), .iq_done_i(s2ev[0]), .pll_lock_i(lock),
    .pwr_pri_o(pri), .pwr_sec_o(sec), .external_amp_control_o(ext), .amp_out_oe_o(amp_oe),
    .rx_unreliable_o(unrel), .preserve_special_o(pres), .base_mult_o(mult), .ref_div_o(div));

  task automatic report_and_stop;
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // one-cycle event pulses, then time for flags and interrupt to register
  task automatic pulse(input logic [6:0] m, input logic [3:0] s);
    @(posedge mclk);
    ev   <= m;
    s2ev <= s;
    @(posedge mclk);
    ev   <= '0;
    s2ev <= 4'h0;
    repeat (5) @(posedge mclk);
  endtask

  task automatic set_lock(input logic [2:0] l);
    @(posedge mclk);
    lock <= l;
    repeat (8) @(posedge mclk);  // async levels pass the synchroniser
  endtask

  task automatic t_reset;
    `CHK("pri", 8'h00, pri)
    `CHK("sec", 8'h00, sec)
    `CHK("irq_n", 1'b1, irq_n)
    `CHK("mult", 5'h10, mult)
    `CHK("div", 5'h10, div)
    `CHK("oe", 1'b0, oe)
  endtask

  task automatic t_power;
    int i;
    host_u.write_reg(ADDR_PWR_SEC, 8'h01);
    host_u.write_reg(ADDR_PWR_PRI, 8'h20);
    host_u.write_reg(ADDR_PWR_PRI, 8'hA0);
    for (i = 0; i < 7; i++) begin
      host_u.write_reg(ADDR_PWR_PRI, 8'hA0 | (8'h01 << i));
      `CHK("pri", 8'hA0 | (8'h01 << i), pri)
      `CHK("amp_oe", i == 4, amp_oe)
    end
    host_u.write_reg(ADDR_PWR_SEC, 8'hF7);
    `CHK("sec", 8'hF7, sec)
    `CHK("ext", 1'b1, ext)
    `CHK("pres", 1'b1, pres)
  endtask

  // each clock setting is checked for its decoded multiplier and divider, a zero nibble giving sixteen
  task automatic t_clock;
    logic [7:0] cfg [3] = '{8'h02, 8'hF0, 8'h48};
    logic [4:0] em [3]  = '{5'h10, 5'h0F, 5'h04};
    logic [4:0] ed [3]  = '{5'h02, 5'h10, 5'h08};
    int i;
    for (i = 0; i < 3; i++) begin
      host_u.write_reg(ADDR_CLK_CFG, cfg[i]);
      `CHK("mult", em[i], mult)
      `CHK("div", ed[i], div)
    end
  endtask

  task automatic t_irq;
    host_u.write_reg(ADDR_MODE, 8'h80);
    pulse(7'h40, 4'h0);
    `CHK("irq_n", 1'b0, irq_n)
    host_u.read_reg(ADDR_MODEM_STAT, rv);
    `CHK("status1", 8'hC0, rv)
    `CHK("irq_n", 1'b1, irq_n)
    host_u.read_reg(ADDR_MODEM_STAT, rv);
    `CHK("status1", 8'h00, rv)
    host_u.write_reg(ADDR_MODE, 8'h00);
    pulse(7'h40, 4'h0);
    `CHK("irq_n", 1'b1, irq_n)
    host_u.read_reg(ADDR_MODEM_STAT, rv);
    `CHK("status1", 8'hC0, rv)
  endtask

  task automatic t_synth_and_aux_status;
    set_lock(3'b111);
    host_u.read_reg(ADDR_SYNTH_STAT, rv);
    `CHK("synth_and_aux_status", 8'h70, rv)
    host_u.write_reg(ADDR_MODE, 8'h88);
    set_lock(3'b101);
    `CHK("irq_n", 1'b0, irq_n)
    host_u.read_reg(ADDR_SYNTH_STAT, rv);
    `CHK("synth_and_aux_status", 8'hD0, rv)
    `CHK("irq_n", 1'b1, irq_n)
    set_lock(3'b111);
    set_lock(3'b101);
    host_u.read_reg(ADDR_SYNTH_STAT, rv);
    `CHK("synth_and_aux_status", 8'h50, rv)
    host_u.write_reg(ADDR_MODE, 8'h00);
    @(posedge mclk);
    rxm <= 1'b1;
    pulse(7'h00, 4'hF);
    host_u.read_reg(ADDR_SYNTH_STAT, rv);
    `CHK("synth_and_aux_status", 8'h5F, rv)
    @(posedge mclk);
    cont <= 1'b1;
    rxm  <= 1'b0;
    pulse(7'h00, 4'h6);
    host_u.read_reg(ADDR_SYNTH_STAT, rv);
    `CHK("synth_and_aux_status", 8'h50, rv)
    @(posedge mclk);
    rxm <= 1'b1;
    pulse(7'h01, 4'h0);
    `CHK("unrel", 1'b1, unrel)
    pulse(7'h00, 4'h1);
    `CHK("unrel", 1'b0, unrel)
  endtask

  task automatic t_soft;
    host_u.write_reg(ADDR_PWR_PRI, 8'hFF);
    host_u.write_reg(ADDR_PWR_SEC, 8'h07);
    host_u.write_reg(ADDR_PWR_SEC, 8'h0B);
    `CHK("pri", 8'h20, pri)
    `CHK("sec", 8'h0B, sec)
    `CHK("ext", 1'b0, ext)
    `CHK("pres", 1'b1, pres)
    `CHK("mult", 5'h04, mult)
    `CHK("div", 5'h08, div)
    host_u.write_reg(ADDR_PWR_PRI, 8'hFF);
    `CHK("pri", 8'h20, pri)
    host_u.write_reg(ADDR_PWR_SEC, 8'h03);
    `CHK("sec", 8'h03, sec)
    host_u.write_reg(ADDR_PWR_PRI, 8'hA0);
    `CHK("pri", 8'hA0, pri)
    host_u.read_reg(6'h3E, rv);
    `CHK("unmapped", 8'h00, rv)
  endtask

  // hang guard: far above the five hundred or so cycles the scenarios need
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      report_and_stop;
    end
  end

  initial begin
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
    t_reset;
    t_power;
    t_clock;
    t_irq;
    t_synth_and_aux_status;
    t_soft;
    report_and_stop;
  end
endmodule

`default_nettype wire
